/* File: verilog/pfc_trim_and_latched_flags.sv */
`timescale 1ns/10ps
// What this block does
// - ov disable mode: re-enable output below ov limit minus hysteresis
// - uv disable mode: re-enable output above uv limit plus hysteresis
// - offset and gain trim writes take effect only while unlocked; hysteresis writes always land
// - line voltage offset trim always subtracted from its samples
// - low/high range current offsets kept apart; active one subtracted
// - high range gain: 7-bit magnitude, bit 7 set means negative
// - flags stay set after condition; read clears register except bits whose condition is still present
// - first flags bit 7 max modulation, bit 6 min modulation
// - first flags bit 5 sense divider suspected open
// - first flags bit 4 fast overvoltage comparator crossed
// - no line period: use maximum period, set first flags bit 3
// - first flags bit 2 when line below turn-on threshold
// - first flags bit 1 during soft start with fast loop filter
// - first flags bit 0 when inrush relay is off
// - second flags bit 6 nonvolatile memory unlocked; bit 7 reserved
// - second flags bit 5 nonvolatile memory integrity check failed
// - second flags bit 4 address strap resistor near code boundary
// - second flags bit 3 input above high line threshold
// - second flags bit 2 fast current limit comparator crossed
// - second flags bit 1 switching locked to external sync
// - second flags bit 0 line good pin driven low
// - sync to external reference enabled by control bit 1
module pfc_trim_and_latched_flags #(
	parameter int SW = pfc_regs_pkg::SAMPLE_W,
	parameter logic [7:0] PERIOD_MAX = 8'hff
) (
	input  wire logic          mclk,
	input  wire logic          srst,
	// register port
	input  wire logic [15:0]   addr,
	input  wire logic [7:0]    wdata,
	input  wire logic          wr,
	input  wire logic          rd,
	output logic      [7:0]    rdata,
	// measurements
	input  wire logic [SW-1:0] vout_sample,
	input  wire logic [SW-1:0] vin_sample,
	input  wire logic [SW-1:0] output_overvoltage_limit,
	input  wire logic [SW-1:0] input_undervoltage_limit,
	input  wire logic          ov_fault,
	input  wire logic          uv_fault,
	output logic               output_enable,
	// converter samples
	input  wire logic [SW-1:0] line_voltage_sense,
	output logic      [SW-1:0] line_voltage_corr,
	input  wire logic [SW-1:0] cs_sample,
	input  wire logic          cs_high_range,
	output logic      [SW-1:0] cs_corr,
	// line period
	input  wire logic [7:0]    period_meas,
	input  wire logic          period_valid,
	output logic      [7:0]    line_period,
	// flag conditions
	input  wire logic          max_mod,
	input  wire logic          min_mod,
	input  wire logic          divider_open_suspect,
	input  wire logic          fast_overvoltage_pin,
	input  wire logic          line_sag_flag,
	input  wire logic          soft_start_fast,
	input  wire logic          inrush_relay_off,
	input  wire logic          nvm_unlocked,
	input  wire logic          nvm_crc_bad,
	input  wire logic          addr_strap_marginal,
	input  wire logic          high_line,
	input  wire logic          current_limit_pin,
	input  wire logic          sync_locked,
	input  wire logic          line_good_low,
	output logic               sync_enable
);
	// trims and control
	logic [7:0] ov_hys, uv_hys, line_ofs, cs_lo_ofs, cs_hi_gain, cs_hi_ofs;
	logic [7:0] ctrl;
	logic [7:0] next_ov_hys, next_uv_hys, next_line_ofs, next_cs_lo_ofs;
	logic [7:0] next_cs_hi_gain, next_cs_hi_ofs, next_ctrl;
	logic       unlocked;

	assign unlocked    = ctrl[pfc_regs_pkg::CTRL_UNLOCK];
	assign sync_enable = ctrl[pfc_regs_pkg::CTRL_SYNC];

	// register writes; offset and gain trims stay untouched while locked, hysteresis always written
	always_comb begin
		next_ov_hys     = ov_hys;
		next_uv_hys     = uv_hys;
		next_line_ofs   = line_ofs;
		next_cs_lo_ofs  = cs_lo_ofs;
		next_cs_hi_gain = cs_hi_gain;
		next_cs_hi_ofs  = cs_hi_ofs;
		next_ctrl       = ctrl;
		if (wr) begin
			unique case (addr)
				pfc_regs_pkg::OFS_OV_HYS:    next_ov_hys = wdata;
				pfc_regs_pkg::OFS_UV_HYS:    next_uv_hys = wdata;
				pfc_regs_pkg::OFS_CTRL:      next_ctrl   = wdata;
				pfc_regs_pkg::OFS_LINE_OFS:
					if (unlocked) next_line_ofs = wdata;
				pfc_regs_pkg::OFS_CS_LO_OFS:
					if (unlocked) next_cs_lo_ofs = wdata;
				pfc_regs_pkg::OFS_CS_HI_GN:
					if (unlocked) next_cs_hi_gain = wdata;
				pfc_regs_pkg::OFS_CS_HI_OFS:
					if (unlocked) next_cs_hi_ofs = wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ov_hys     <= pfc_regs_pkg::RST_TRIM;
			uv_hys     <= pfc_regs_pkg::RST_TRIM;
			line_ofs   <= pfc_regs_pkg::RST_TRIM;
			cs_lo_ofs  <= pfc_regs_pkg::RST_TRIM;
			cs_hi_gain <= pfc_regs_pkg::RST_TRIM;
			cs_hi_ofs  <= pfc_regs_pkg::RST_TRIM;
			ctrl       <= pfc_regs_pkg::RST_CTRL;
		end else begin
			ov_hys     <= next_ov_hys;
			uv_hys     <= next_uv_hys;
			line_ofs   <= next_line_ofs;
			cs_lo_ofs  <= next_cs_lo_ofs;
			cs_hi_gain <= next_cs_hi_gain;
			cs_hi_ofs  <= next_cs_hi_ofs;
			ctrl       <= next_ctrl;
		end
	end

	// pin-level comparator inputs cross two flops before use
	logic [1:0] ov_trip_sync, oc_trip_sync;
	always_ff @(posedge mclk) begin
		if (srst) begin
			ov_trip_sync <= 2'h0;
			oc_trip_sync <= 2'h0;
		end else begin
			ov_trip_sync <= {ov_trip_sync[0], fast_overvoltage_pin};
			oc_trip_sync <= {oc_trip_sync[0], current_limit_pin};
		end
	end

	// output re-arm with hysteresis, only in disable-output mode
	logic [1:0]  ov_act, uv_act;
	logic        ov_latched, uv_latched, next_ov_latched, next_uv_latched;
	logic [SW:0] ov_rearm, uv_rearm;

	assign ov_act = ctrl[pfc_regs_pkg::CTRL_OV_ACT +: pfc_regs_pkg::ACT_W];
	assign uv_act = ctrl[pfc_regs_pkg::CTRL_UV_ACT +: pfc_regs_pkg::ACT_W];
	// one extra bit flags limit minus hysteresis going below zero and keeps limit plus hysteresis from wrapping
	assign ov_rearm = {1'b0, output_overvoltage_limit} - (SW+1)'(ov_hys);
	assign uv_rearm = {1'b0, input_undervoltage_limit} + (SW+1)'(uv_hys);

	always_comb begin
		next_ov_latched = ov_latched;
		next_uv_latched = uv_latched;
		if (ov_act != pfc_regs_pkg::ACT_DISABLE) begin
			next_ov_latched = 1'b0;
		end else if (ov_fault) begin
			next_ov_latched = 1'b1;
		end else if (!ov_rearm[SW] &&
			{1'b0, vout_sample} < ov_rearm) begin
			next_ov_latched = 1'b0;
		end
		if (uv_act != pfc_regs_pkg::ACT_DISABLE) begin
			next_uv_latched = 1'b0;
		end else if (uv_fault) begin
			next_uv_latched = 1'b1;
		end else if ({1'b0, vin_sample} > uv_rearm) begin
			next_uv_latched = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ov_latched <= 1'b0;
			uv_latched <= 1'b0;
		end else begin
			ov_latched <= next_ov_latched;
			uv_latched <= next_uv_latched;
		end
	end

	// sample corrections and period substitution
	logic [SW-1:0] cs_ofs_sub, cs_after_ofs, gain_delta, next_line, next_cs;
	logic [SW+6:0] gain_prod;
	logic [7:0]    next_period;
	logic          next_out_en;

	always_comb begin
		next_line  = line_voltage_sense - SW'(line_ofs);
		cs_ofs_sub = cs_high_range ? SW'(cs_hi_ofs) : SW'(cs_lo_ofs);
		cs_after_ofs = cs_sample - cs_ofs_sub;
		// magnitude scales sample by mag/128
		gain_prod  = (SW+7)'(cs_after_ofs) *
			(SW+7)'(cs_hi_gain[pfc_regs_pkg::GAIN_MAG_W-1:0]);
		gain_delta = gain_prod[SW+6:7];
		if (!cs_high_range) begin
			next_cs = cs_after_ofs;
		end else if (cs_hi_gain[pfc_regs_pkg::GAIN_SIGN]) begin
			next_cs = cs_after_ofs - gain_delta;
		end else begin
			next_cs = cs_after_ofs + gain_delta;
		end
		next_period = period_valid ? period_meas : PERIOD_MAX;
		next_out_en = !next_ov_latched && !next_uv_latched;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			line_voltage_corr <= '0;
			cs_corr           <= '0;
			line_period       <= 8'h00;
			output_enable     <= 1'b0;
		end else begin
			line_voltage_corr <= next_line;
			cs_corr           <= next_cs;
			line_period       <= next_period;
			output_enable     <= next_out_en;
		end
	end

	// flag conditions, bit order as the flag registers read
	logic [7:0] cond0, cond1, flags0, flags1;
	logic       rd_f0, rd_f1;

	assign cond0 = {max_mod, min_mod,
		divider_open_suspect,
		ov_trip_sync[1],
		!period_valid,
		line_sag_flag,
		soft_start_fast,
		inrush_relay_off};
	assign cond1 = {1'b0, nvm_unlocked,
		nvm_crc_bad,
		addr_strap_marginal,
		high_line,
		oc_trip_sync[1],
		sync_locked && sync_enable,
		line_good_low};
	assign rd_f0 = rd && (addr == pfc_regs_pkg::OFS_FLAGS0);
	assign rd_f1 = rd && (addr == pfc_regs_pkg::OFS_FLAGS1);

	sticky_flags #(.W(8)) u_flags0 (
		.mclk   (mclk),
		.srst   (srst),
		.cond   (cond0),
		.rd_clr (rd_f0),
		.flags  (flags0)
	);

	sticky_flags #(.W(8)) u_flags1 (
		.mclk   (mclk),
		.srst   (srst),
		.cond   (cond1 & pfc_regs_pkg::FLAGS1_RSVD_MASK),
		.rd_clr (rd_f1),
		.flags  (flags1)
	);

	// read mux registered, data valid the cycle after the strobe
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = 8'h00;
		if (rd) begin
			unique case (addr)
				pfc_regs_pkg::OFS_OV_HYS:    next_rdata = ov_hys;
				pfc_regs_pkg::OFS_UV_HYS:    next_rdata = uv_hys;
				pfc_regs_pkg::OFS_LINE_OFS:  next_rdata = line_ofs;
				pfc_regs_pkg::OFS_CS_LO_OFS: next_rdata = cs_lo_ofs;
				pfc_regs_pkg::OFS_CS_HI_GN:  next_rdata = cs_hi_gain;
				pfc_regs_pkg::OFS_CS_HI_OFS: next_rdata = cs_hi_ofs;
				pfc_regs_pkg::OFS_FLAGS0:    next_rdata = flags0;
				pfc_regs_pkg::OFS_FLAGS1:    next_rdata = flags1;
				pfc_regs_pkg::OFS_CTRL:      next_rdata = ctrl;
				default:                     next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	// checks
	a_trim_locked: assert property (@(posedge mclk) disable iff (srst)
		(wr && !unlocked && addr == pfc_regs_pkg::OFS_LINE_OFS)
		|=> $stable(line_ofs))
		else $error("trim changed while locked");
	a_cs_trim_locked: assert property (@(posedge mclk) disable iff (srst)
		(wr && !unlocked && addr == pfc_regs_pkg::OFS_CS_LO_OFS)
		|=> $stable(cs_lo_ofs))
		else $error("current trim changed while locked");
	a_read_clears: assert property (@(posedge mclk) disable iff (srst)
		(rd_f0 && cond0 == 8'h00) |=> flags0 == 8'h00)
		else $error("flags0 not cleared by read");
	a_read_keeps: assert property (@(posedge mclk) disable iff (srst)
		(rd_f1 && cond1[3]) |=> flags1[3] ##1 1'b1)
		else $error("event lost during read");
	a_rsvd_zero: assert property (@(posedge mclk) disable iff (srst)
		!flags1[7])
		else $error("reserved flag bit set");
	a_period_sub: assert property (@(posedge mclk) disable iff (srst)
		!period_valid |=> line_period == PERIOD_MAX && flags0[3])
		else $error("period not substituted");
	a_line_offset: assert property (@(posedge mclk) disable iff (srst)
		1'b1 |=> line_voltage_corr ==
		SW'($past(line_voltage_sense) - SW'($past(line_ofs))))
		else $error("line offset not applied");
	a_ov_hold: assert property (@(posedge mclk) disable iff (srst)
		(ov_fault && ov_act == pfc_regs_pkg::ACT_DISABLE)
		|=> !output_enable)
		else $error("output on during ov fault");
	a_uv_hold: assert property (@(posedge mclk) disable iff (srst)
		(uv_fault && uv_act == pfc_regs_pkg::ACT_DISABLE)
		|=> !output_enable)
		else $error("output on during uv fault");
	a_cs_lowrange: assert property (@(posedge mclk) disable iff (srst)
		!cs_high_range |=> cs_corr ==
		SW'($past(cs_sample) - SW'($past(cs_lo_ofs))))
		else $error("low range offset wrong");
	a_ov_trip_flag: assert property (@(posedge mclk) disable iff (srst)
		fast_overvoltage_pin |-> ##3 flags0[4])
		else $error("fast ov flag missing");
	a_oc_trip_flag: assert property (@(posedge mclk) disable iff (srst)
		current_limit_pin |-> ##3 flags1[2])
		else $error("fast current flag missing");
	// read data stands one cycle only, so an idle bus must read zero
	a_rdata_idle: assert property (@(posedge mclk) disable iff (srst)
		!rd |=> rdata == 8'h00)
		else $error("read data outside read cycle");

	c_trim_write: cover property (@(posedge mclk)
		wr && unlocked && addr == pfc_regs_pkg::OFS_CS_HI_GN);
	c_flag_read: cover property (@(posedge mclk) rd_f0 && flags0 != 8'h00);
	c_ov_rearm: cover property (@(posedge mclk)
		ov_latched ##1 !ov_latched);
	c_neg_gain: cover property (@(posedge mclk)
		cs_high_range && cs_hi_gain[pfc_regs_pkg::GAIN_SIGN]);
	c_uv_rearm: cover property (@(posedge mclk)
		uv_latched ##1 !uv_latched);
endmodule

/* File: verilog/pfc_regs_pkg.sv */
package pfc_regs_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// register offsets
	localparam logic [15:0] OFS_OV_HYS    = 16'hfe50;
	localparam logic [15:0] OFS_UV_HYS    = 16'hfe51;
	localparam logic [15:0] OFS_LINE_OFS  = 16'hfe53;
	localparam logic [15:0] OFS_CS_LO_OFS = 16'hfe54;
	localparam logic [15:0] OFS_CS_HI_GN  = 16'hfe7e;
	localparam logic [15:0] OFS_CS_HI_OFS = 16'hfe7f;
	localparam logic [15:0] OFS_FLAGS0    = 16'hfe80;
	localparam logic [15:0] OFS_FLAGS1    = 16'hfe81;
	// control register for this block's own switches
	localparam logic [15:0] OFS_CTRL      = 16'hfef0;

	// control register fields
	localparam int CTRL_UNLOCK = 0;
	localparam int CTRL_SYNC   = 1;
	localparam int CTRL_OV_ACT = 2;
	localparam int CTRL_UV_ACT = 4;
	localparam int ACT_W       = 2;
	localparam logic [1:0] ACT_DISABLE = 2'h2;

	// gain trim fields
	localparam int GAIN_SIGN = 7;
	localparam int GAIN_MAG_W = 7;

	// reset values and reserved flag mask
	localparam logic [7:0] RST_TRIM  = 8'h00;
	localparam logic [7:0] RST_CTRL  = 8'h00;
	localparam logic [7:0] FLAGS1_RSVD_MASK = 8'h7f;

	// sample widths
	localparam int SAMPLE_W = 12;
endpackage

/* File: verilog/sticky_flags.sv */
`timescale 1ns/10ps
// one latched flag byte: set by a condition, cleared by a read
module sticky_flags #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         srst,
	input  wire logic [W-1:0] cond,
	input  wire logic         rd_clr,
	output logic      [W-1:0] flags
);
	logic [W-1:0] next_flags;

	// set beats clear, so an event during the read survives to the next one
	always_comb begin
		next_flags = (rd_clr ? '0 : flags) | cond;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			flags <= '0;
		end else begin
			flags <= next_flags;
		end
	end

	// with no read, no set bit may fall in the next cycle
	a_flag_holds: assert property (@(posedge mclk) disable iff (srst)
		!rd_clr |=> ((flags & $past(flags)) == $past(flags)))
		else $error("flag bit dropped without read");
endmodule

/* File: testbench/pfc_host_model.sv */
`timescale 1ns/10ps
// management-side master: one-cycle strobes, the slave never stalls
module pfc_host_model (
	input  wire logic        mclk,
	input  wire logic [7:0]  rdata,
	output logic      [15:0] addr,
	output logic      [7:0]  wdata,
	output logic             wr,
	output logic             rd
);
	initial begin
		addr = 16'h0000;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end

	// strobe, address and data stand together for exactly one edge
	task automatic write(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	// data stands only in the cycle after the strobe, so take it at that edge
	task automatic read(input logic [15:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(posedge mclk);
		d = rdata;
	endtask
endmodule

/* File: testbench/pfc_trim_and_latched_flags_tb.sv */
`timescale 1ns/10ps
module pfc_trim_and_latched_flags_tb;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic [15:0] addr;
	logic [7:0]  wdata;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic [11:0] vout = 12'h000;
	logic [11:0] vin = 12'h200;
	logic [11:0] ovl = 12'h300;
	logic [11:0] uvl = 12'h100;
	logic        ovf = 1'b0;
	logic        uvf = 1'b0;
	logic        oe;
	logic [11:0] lvs = 12'h100;
	logic [11:0] lvc;
	logic [11:0] css = 12'h200;
	logic        csh = 1'b0;
	logic [11:0] csc;
	logic [7:0]  pmeas = 8'h4c;
	logic [7:0]  lper;
	logic [15:0] c = 16'h0000;
	logic        sync_en;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;

	// 200 MHz
	always #2.5 mclk = ~mclk;

	pfc_host_model pfc_host_model_i (.mclk(mclk), .rdata(rdata),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd));

	// condition vector: low byte first flag byte, bits 14:8 second byte
	pfc_trim_and_latched_flags pfc_trim_and_latched_flags_i (
		.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .vout_sample(vout), .vin_sample(vin),
		.output_overvoltage_limit(ovl), .input_undervoltage_limit(uvl),
		.ov_fault(ovf), .uv_fault(uvf), .output_enable(oe),
		.line_voltage_sense(lvs), .line_voltage_corr(lvc),
		.cs_sample(css), .cs_high_range(csh), .cs_corr(csc),
		.period_meas(pmeas), .period_valid(~c[3]), .line_period(lper),
		.max_mod(c[7]), .min_mod(c[6]), .divider_open_suspect(c[5]),
		.fast_overvoltage_pin(c[4]), .line_sag_flag(c[2]),
		.soft_start_fast(c[1]), .inrush_relay_off(c[0]),
		.nvm_unlocked(c[14]), .nvm_crc_bad(c[13]),
		.addr_strap_marginal(c[12]), .high_line(c[11]),
		.current_limit_pin(c[10]), .sync_locked(c[9]),
		.line_good_low(c[8]), .sync_enable(sync_en));

	task automatic check(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		pfc_host_model_i.read(a, d);
		check(d, e);
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		pfc_host_model_i.write(a, d);
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// cuts a hang short; the whole run needs far fewer cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end

	// locked trim write dropped, then unlocked writes land
	task automatic t_lock;
		rd_chk(16'hfe52, 8'h00);
		check(sync_en, 1'b0);
		wr_reg(pfc_regs_pkg::OFS_LINE_OFS, 8'h55);
		wr_reg(pfc_regs_pkg::OFS_CS_LO_OFS, 8'h55);
		rd_chk(pfc_regs_pkg::OFS_LINE_OFS, 8'h00);
		rd_chk(pfc_regs_pkg::OFS_CS_LO_OFS, 8'h00);
		wr_reg(pfc_regs_pkg::OFS_CTRL, 8'h03);
		// control updates on the edge that takes the write, look one later
		@(posedge mclk);
		check(sync_en, 1'b1);
		wr_reg(pfc_regs_pkg::OFS_LINE_OFS, 8'h12);
		wr_reg(pfc_regs_pkg::OFS_CS_LO_OFS, 8'h21);
		wr_reg(pfc_regs_pkg::OFS_CS_HI_GN, 8'h40);
		wr_reg(pfc_regs_pkg::OFS_CS_HI_OFS, 8'h10);
		wr_reg(pfc_regs_pkg::OFS_OV_HYS, 8'h20);
		wr_reg(pfc_regs_pkg::OFS_UV_HYS, 8'h10);
		rd_chk(pfc_regs_pkg::OFS_LINE_OFS, 8'h12);
		rd_chk(pfc_regs_pkg::OFS_CS_HI_GN, 8'h40);
		rd_chk(pfc_regs_pkg::OFS_UV_HYS, 8'h10);
	endtask

	// offsets subtracted; high range gain of 64/128 added, then taken off
	task automatic t_corr;
		check(lvc, 12'h0ee);
		check(csc, 12'h1df);
		@(posedge mclk) csh <= 1'b1;
		repeat (2) @(posedge mclk);
		check(csc, 12'h2e8);
		wr_reg(pfc_regs_pkg::OFS_CS_HI_GN, 8'hc0);
		repeat (2) @(posedge mclk);
		check(csc, 12'h0f8);
	endtask

	// each condition pulsed alone: its bit latches, a read clears it
	task automatic t_flags;
		logic [15:0] a;
		for (int i = 0; i < 15; i++) begin
			@(posedge mclk) c <= 16'h0001 << i;
			repeat (2) @(posedge mclk);
			if (i == 3)
				check(lper, 8'hff);
			c <= 16'h0000;
			repeat (4) @(posedge mclk);
			a = (i < 8) ? pfc_regs_pkg::OFS_FLAGS0 : pfc_regs_pkg::OFS_FLAGS1;
			rd_chk(a, 8'h01 << (i % 8));
			rd_chk(a, 8'h00);
		end
		check(lper, 8'h4c);
	endtask

	// a condition present during the clearing read survives it
	task automatic t_sticky;
		@(posedge mclk) c <= 16'h0880;
		repeat (2) @(posedge mclk);
		rd_chk(pfc_regs_pkg::OFS_FLAGS0, 8'h80);
		rd_chk(pfc_regs_pkg::OFS_FLAGS0, 8'h80);
		rd_chk(pfc_regs_pkg::OFS_FLAGS1, 8'h08);
		rd_chk(pfc_regs_pkg::OFS_FLAGS1, 8'h08);
		c <= 16'h0000;
		repeat (2) @(posedge mclk);
		rd_chk(pfc_regs_pkg::OFS_FLAGS0, 8'h80);
		rd_chk(pfc_regs_pkg::OFS_FLAGS0, 8'h00);
		rd_chk(pfc_regs_pkg::OFS_FLAGS1, 8'h08);
		rd_chk(pfc_regs_pkg::OFS_FLAGS1, 8'h00);
	endtask

	// pulse one fault input for one cycle, then let the latch settle
	task automatic pulse(input logic ov);
		@(posedge mclk) begin
			ovf <= ov;
			uvf <= !ov;
		end
		@(posedge mclk) begin
			ovf <= 1'b0;
			uvf <= 1'b0;
		end
		repeat (3) @(posedge mclk);
	endtask

	// re-enable only strictly past the limit with hysteresis
	task automatic t_rearm;
		pulse(1'b1);
		check(oe, 1'b1);
		wr_reg(pfc_regs_pkg::OFS_CTRL, 8'h2b);
		vout <= 12'h2e0;
		pulse(1'b1);
		check(oe, 1'b0);
		@(posedge mclk) vout <= 12'h2df;
		repeat (3) @(posedge mclk);
		check(oe, 1'b1);
		vin <= 12'h110;
		pulse(1'b0);
		check(oe, 1'b0);
		@(posedge mclk) vin <= 12'h111;
		repeat (3) @(posedge mclk);
		check(oe, 1'b1);
	endtask

	initial begin
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		t_lock();
		t_corr();
		t_flags();
		t_sticky();
		t_rearm();
		report_and_stop();
	end
endmodule
